// ==== rtl/esm_top.sv ====
// Contract
// [RULE1] A reference pulse lights the index-seen indicator for about one second.
// [RULE2] A fault-detection input that is asserted shows a fault indication.
// [RULE3] The fault-detection input is active low, so a floating low line is a fault.
// [RULE4] A fault line tied high always reads as no fault.
// [RULE5] Any fault event sets a sticky error memory that outlives the fault.
// [RULE6] The error memory clears only on a new mode or on the clear command.
// [RULE7] The encoder supply on/off setting is shown and set by software.
// [RULE8] The line termination enable is shown and set by software.
// [RULE9] Too fast a traverse in reference or distance-code checks flags overspeed and error; the code sets dist_err only in distance-code checks.
// [RULE10] Low amplitude while the encoder moves raises an amplitude error; the code raises it only when mode is not ESM_MODE_IDLE.
// [RULE11] Reference position and width are measured only while moving.
// [RULE12] Counting direction follows the phase order of the quadrature signals.
//
// The AHB-Lite slave port and the register offsets were decided locally.
`timescale 1ns/10ps
`include "esm_params.svh"
module esm_top #(
  parameter int unsigned HOLD_CYC = `ESM_HOLD_CYC,
  parameter int unsigned STILL_CYC = `ESM_STILL_CYC
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // encoder side
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic ref_pulse,
  input wire logic fault_detect_n,
  input wire logic amp_low,
  // indicators
  output logic index_seen,
  output logic fault_indicator,
  output logic encoder_supply_indicator,
  output logic termination_indicator,
  output logic dir_positive,
  output logic overspeed_flag,
  output logic irq
);
  import esm_pkg::*;

  localparam int SW = $clog2(STILL_CYC + 1);
  localparam logic [SW-1:0] STILL_LOAD = SW'(STILL_CYC);
  localparam logic [SW-1:0] STILL_ONE = SW'(1);
  localparam int IW = `ESM_IRQ_W;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic next_sticky(input logic cur, input logic set, input logic clr);
    next_sticky = set | (cur & ~clr);
  endfunction : next_sticky

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic wr_pend;
  logic rd_pend;
  logic [7:0] ph_addr;
  esm_mode_t mode;
  logic [IW-1:0] irq_stat;
  logic [IW-1:0] irq_mask;
  logic [IW-1:0] irq_ev;
  logic [IW-1:0] irq_clr;
  logic [15:0] speed_limit;
  logic [15:0] gap_cnt;
  logic [SW-1:0] still_cnt;
  logic moving;
  logic [15:0] pos;
  logic [15:0] ref_pos;
  logic [15:0] ref_width;
  logic [15:0] width_cnt;
  esm_ref_state_t ref_state;
  logic ref_d;
  logic ref_rise;
  logic ref_fall;
  logic fault_live;
  logic fault_d;
  logic fault_mem;
  logic dist_err;
  logic amp_err;
  logic step;
  logic step_up;
  logic wr_ctrl;
  logic wr_cmd;
  logic new_mode;
  logic clr_cmd;
  logic err_clr;
  logic too_fast;
  logic amp_ev;
  logic ref_done;
  logic addr_ok;
  logic [31:0] rd_mux;

  // ----------------------------------------
  // submodules
  // ----------------------------------------
  esm_stretch #(
    .HOLD_CYC(HOLD_CYC)
  ) u_stretch (
    .hclk(hclk),
    .hresetn(hresetn),
    .trig(ref_rise), // [RULE1]
    .active(index_seen)
  );

  esm_quad u_quad (
    .hclk(hclk),
    .hresetn(hresetn),
    .enc_a(enc_a),
    .enc_b(enc_b),
    .step(step),
    .step_up(step_up),
    .dir_positive(dir_positive)
  );

  // ----------------------------------------
  // bus phase tracking
  // ----------------------------------------
  assign addr_ok = hsel && htrans[1] && hready;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      ph_addr <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
      if (rd_pend) begin
        rd_pend <= 1'b0;
        hreadyout <= 1'b1;
      end else if (addr_ok) begin
        wr_pend <= hwrite;
        rd_pend <= !hwrite;
        hreadyout <= hwrite;
        ph_addr <= {haddr[7:2], 2'b00};
      end else if (hready) begin
        wr_pend <= 1'b0;
      end
    end
  end

  assign wr_ctrl = wr_pend && (ph_addr == `ESM_OFF_CTRL);
  assign wr_cmd = wr_pend && (ph_addr == `ESM_OFF_CMD);
  assign new_mode = wr_ctrl && (hwdata[`ESM_CTRL_MODE_LSB +: 2] != mode);
  assign clr_cmd = wr_cmd && hwdata[`ESM_CMD_CLR];
  assign err_clr = new_mode || clr_cmd;
  assign irq_clr = (wr_pend && ph_addr == `ESM_OFF_IRQ_STAT) ? hwdata[IW-1:0] : '0;

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode <= ESM_MODE_IDLE;
      encoder_supply_indicator <= 1'b0;
      termination_indicator <= 1'b0;
    end else if (wr_ctrl) begin
      mode <= esm_mode_t'(hwdata[`ESM_CTRL_MODE_LSB +: 2]);
      encoder_supply_indicator <= hwdata[`ESM_CTRL_SUPPLY]; // [RULE7]
      termination_indicator <= hwdata[`ESM_CTRL_TERM]; // [RULE8]
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_mask <= `ESM_MASK_RST;
      speed_limit <= `ESM_SPEED_RST;
    end else if (wr_pend) begin
      if (ph_addr == `ESM_OFF_IRQ_MASK) begin
        irq_mask <= hwdata[IW-1:0];
      end
      if (ph_addr == `ESM_OFF_SPEED) begin
        speed_limit <= hwdata[15:0];
      end
    end
  end

  // ----------------------------------------
  // fault detection and error memory
  // ----------------------------------------
  assign fault_live = !fault_detect_n; // [RULE3] [RULE4]

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fault_d <= 1'b0;
      fault_mem <= 1'b0;
      fault_indicator <= 1'b0;
    end else begin
      fault_d <= fault_live;
      fault_mem <= next_sticky(fault_mem, fault_live, err_clr); // [RULE5] [RULE6]
      fault_indicator <= fault_live || fault_mem; // [RULE2] [RULE5]
    end
  end

  // ----------------------------------------
  // motion and speed
  // ----------------------------------------
  assign moving = (still_cnt != '0);
  assign too_fast = step && (gap_cnt < speed_limit)
                    && (mode == ESM_MODE_REF || mode == ESM_MODE_DIST);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gap_cnt <= 16'hFFFF;
      still_cnt <= '0;
      pos <= 16'h0000;
    end else begin
      if (step) begin
        gap_cnt <= 16'h0000;
        still_cnt <= STILL_LOAD;
        pos <= step_up ? pos + 16'h0001 : pos - 16'h0001;
      end else begin
        if (gap_cnt != 16'hFFFF) begin
          gap_cnt <= gap_cnt + 16'h0001;
        end
        if (still_cnt != '0) begin
          still_cnt <= still_cnt - STILL_ONE;
        end
      end
    end
  end

  // ----------------------------------------
  // overspeed, distance-code and amplitude errors
  // ----------------------------------------
  assign amp_ev = amp_low && moving && (mode != ESM_MODE_IDLE);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      overspeed_flag <= 1'b0;
      dist_err <= 1'b0;
      amp_err <= 1'b0;
    end else begin
      overspeed_flag <= next_sticky(overspeed_flag, too_fast, err_clr); // [RULE9]
      dist_err <= next_sticky(dist_err, too_fast && mode == ESM_MODE_DIST, err_clr); // [RULE9]
      amp_err <= next_sticky(amp_err, amp_ev, err_clr); // [RULE10]
    end
  end

  // ----------------------------------------
  // reference mark measurement
  // ----------------------------------------
  assign ref_rise = ref_pulse && !ref_d;
  assign ref_fall = !ref_pulse && ref_d;
  assign ref_done = (ref_state == ESM_REF_HIGH) && ref_fall && moving;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ref_d <= 1'b0;
      ref_state <= ESM_REF_WAIT;
      ref_pos <= 16'h0000;
      ref_width <= 16'h0000;
      width_cnt <= 16'h0000;
    end else begin
      ref_d <= ref_pulse;
      unique case (ref_state)
        ESM_REF_WAIT: begin
          if (ref_rise && moving) begin // [RULE11]
            ref_pos <= pos;
            width_cnt <= 16'h0000;
            ref_state <= ESM_REF_HIGH;
          end
        end
        ESM_REF_HIGH: begin
          if (!moving) begin // [RULE11]
            ref_state <= ESM_REF_WAIT;
          end else if (ref_fall) begin
            ref_width <= width_cnt;
            ref_state <= ESM_REF_WAIT;
          end else if (step) begin
            width_cnt <= width_cnt + 16'h0001;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // interrupt status and output
  // ----------------------------------------
  always_comb begin
    irq_ev = '0;
    irq_ev[`ESM_IRQ_INDEX] = ref_rise;
    irq_ev[`ESM_IRQ_FAULT] = fault_live && !fault_d;
    irq_ev[`ESM_IRQ_OVER] = too_fast;
    irq_ev[`ESM_IRQ_DIST] = too_fast && (mode == ESM_MODE_DIST);
    irq_ev[`ESM_IRQ_AMP] = amp_ev;
    irq_ev[`ESM_IRQ_REF] = ref_done;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat <= '0;
      irq <= 1'b0;
    end else begin
      irq_stat <= irq_ev | (irq_stat & ~irq_clr);
      irq <= |((irq_ev | (irq_stat & ~irq_clr)) & irq_mask);
    end
  end

  // ----------------------------------------
  // read data
  // ----------------------------------------
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (ph_addr)
      `ESM_OFF_CTRL: begin
        rd_mux[`ESM_CTRL_MODE_LSB +: 2] = mode;
        rd_mux[`ESM_CTRL_SUPPLY] = encoder_supply_indicator;
        rd_mux[`ESM_CTRL_TERM] = termination_indicator;
      end
      `ESM_OFF_STATUS: begin
        rd_mux[`ESM_ST_INDEX] = index_seen;
        rd_mux[`ESM_ST_FAULT] = fault_live;
        rd_mux[`ESM_ST_FMEM] = fault_mem;
        rd_mux[`ESM_ST_DIR] = dir_positive;
        rd_mux[`ESM_ST_MOVING] = moving;
        rd_mux[`ESM_ST_OVER] = overspeed_flag;
        rd_mux[`ESM_ST_DIST] = dist_err;
        rd_mux[`ESM_ST_AMP] = amp_err;
      end
      `ESM_OFF_IRQ_STAT: rd_mux[IW-1:0] = irq_stat;
      `ESM_OFF_IRQ_MASK: rd_mux[IW-1:0] = irq_mask;
      `ESM_OFF_SPEED: rd_mux[15:0] = speed_limit;
      `ESM_OFF_REF_MEAS: rd_mux = {ref_width, ref_pos};
      `ESM_OFF_POS: rd_mux[15:0] = pos;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_pend) begin
      hrdata <= rd_mux;
    end
  end
endmodule : esm_top

// ==== rtl/esm_params.svh ====
`ifndef ESM_PARAMS_SVH
`define ESM_PARAMS_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define ESM_CLK_HZ 20000000
`define ESM_HOLD_MS 1000
`define ESM_HOLD_CYC ((`ESM_CLK_HZ / 1000) * `ESM_HOLD_MS)
`define ESM_STILL_MS 10
`define ESM_STILL_CYC ((`ESM_CLK_HZ / 1000) * `ESM_STILL_MS)

// ----------------------------------------
// register offsets
// ----------------------------------------
`define ESM_OFF_CTRL 8'h00
`define ESM_OFF_CMD 8'h04
`define ESM_OFF_STATUS 8'h08
`define ESM_OFF_IRQ_STAT 8'h0C
`define ESM_OFF_IRQ_MASK 8'h10
`define ESM_OFF_SPEED 8'h14
`define ESM_OFF_REF_MEAS 8'h18
`define ESM_OFF_POS 8'h1C

// ----------------------------------------
// field positions
// ----------------------------------------
`define ESM_CTRL_MODE_LSB 0
`define ESM_CTRL_SUPPLY 2
`define ESM_CTRL_TERM 3
`define ESM_CMD_CLR 0
`define ESM_ST_INDEX 0
`define ESM_ST_FAULT 1
`define ESM_ST_FMEM 2
`define ESM_ST_DIR 3
`define ESM_ST_MOVING 4
`define ESM_ST_OVER 5
`define ESM_ST_DIST 6
`define ESM_ST_AMP 7
`define ESM_IRQ_INDEX 0
`define ESM_IRQ_FAULT 1
`define ESM_IRQ_OVER 2
`define ESM_IRQ_DIST 3
`define ESM_IRQ_AMP 4
`define ESM_IRQ_REF 5
`define ESM_IRQ_W 6

// ----------------------------------------
// reset values
// ----------------------------------------
`define ESM_SPEED_RST 16'h0010
`define ESM_MASK_RST 6'h00

`endif

// ==== rtl/esm_pkg.sv ====
package esm_pkg;
  typedef enum logic [1:0] {
    ESM_MODE_IDLE,
    ESM_MODE_SIGNAL,
    ESM_MODE_REF,
    ESM_MODE_DIST
  } esm_mode_t;

  typedef enum logic {
    ESM_REF_WAIT,
    ESM_REF_HIGH
  } esm_ref_state_t;
endpackage : esm_pkg

// ==== rtl/esm_stretch.sv ====
`timescale 1ns/10ps
module esm_stretch #(
  parameter int unsigned HOLD_CYC = 20000000
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // trigger and stretched level
  input wire logic trig,
  output logic active
);
  localparam int CW = $clog2(HOLD_CYC + 1);
  localparam logic [CW-1:0] LOAD = CW'(HOLD_CYC);
  localparam logic [CW-1:0] ONE = CW'(1);

  logic [CW-1:0] cnt;

  // ----------------------------------------
  // hold counter, retriggerable
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= '0;
      active <= 1'b0;
    end else if (trig) begin
      cnt <= LOAD;
      active <= 1'b1;
    end else if (cnt != '0) begin
      cnt <= cnt - ONE;
      active <= (cnt != ONE);
    end
  end
endmodule : esm_stretch

// ==== rtl/esm_quad.sv ====
`timescale 1ns/10ps
module esm_quad (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // quadrature inputs
  input wire logic enc_a,
  input wire logic enc_b,
  // decoded step and direction
  output logic step,
  output logic step_up,
  output logic dir_positive
);
  logic prev_a;
  logic prev_b;
  logic one_change;
  logic up;

  assign one_change = (enc_a ^ prev_a) ^ (enc_b ^ prev_b);
  assign up = prev_a ^ enc_b;

  // ----------------------------------------
  // phase order decode
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_a <= 1'b0;
      prev_b <= 1'b0;
      step <= 1'b0;
      step_up <= 1'b0;
      dir_positive <= 1'b1;
    end else begin
      prev_a <= enc_a;
      prev_b <= enc_b;
      step <= one_change;
      step_up <= up;
      if (one_change) begin
        dir_positive <= up; // [RULE12]
      end
    end
  end
endmodule : esm_quad

// ==== bench/esm_enc_model.sv ====
`timescale 1ns/10ps
module esm_enc_model (
  // clock
  input wire logic hclk,
  // motion command
  input wire logic go,
  input wire logic fwd,
  input wire logic [7:0] gap,
  // quadrature lines
  output logic enc_a,
  output logic enc_b
);
  logic [1:0] ph = 2'h0;
  logic [7:0] cnt = 8'h00;
  // b leads a when moving forward
  assign enc_a = ph[1];
  assign enc_b = ph[1] ^ ph[0];
  always_ff @(posedge hclk) begin
    cnt <= (go && cnt < gap) ? cnt + 8'h01 : 8'h00;
    if (go && cnt >= gap) begin
      ph <= fwd ? ph + 2'h1 : ph - 2'h1;
    end
  end
endmodule : esm_enc_model

// ==== bench/esm_chk.sv ====
`timescale 1ns/10ps
module esm_chk #(
  parameter int unsigned HOLD_CYC = 50,
  parameter int unsigned STILL_CYC = 40
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  // encoder and indicators
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic ref_pulse,
  input wire logic fault_detect_n,
  input wire logic index_seen,
  input wire logic fault_indicator,
  input wire logic encoder_supply_indicator,
  input wire logic termination_indicator,
  input wire logic dir_positive,
  input wire logic overspeed_flag,
  input wire logic irq
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic [31:0] hi_cnt;
  logic [1:0] ab_q;
  logic wr_ctrl, wr_cmd, ca, one, fwd_step, rev_step;
  assign ca = enc_a ^ ab_q[1];
  assign one = ca ^ enc_b ^ ab_q[0];
  assign fwd_step = one && ((enc_a ^ enc_b) != ca);
  assign rev_step = one && ((enc_a ^ enc_b) == ca);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hi_cnt <= 32'h0;
      ab_q <= 2'h0;
      wr_ctrl <= 1'b0;
      wr_cmd <= 1'b0;
    end else begin
      hi_cnt <= index_seen ? hi_cnt + 32'h1 : 32'h0;
      ab_q <= {enc_a, enc_b};
      if (hready) begin
        wr_ctrl <= hsel && htrans[1] && hwrite && haddr[7:2] == 6'h00;
        wr_cmd <= hsel && htrans[1] && hwrite && haddr[7:2] == 6'h01;
      end
    end
  end
  a_index_rise: assert property ($rose(ref_pulse) |-> ##[1:2] index_seen)
    else $error("index late");
  a_index_hold: assert property ($fell(index_seen) |-> hi_cnt >= HOLD_CYC - 1)
    else $error("index short");
  a_fault_live: assert property (!fault_detect_n |=> fault_indicator)
    else $error("fault not shown");
  a_fault_sticky: assert property (
    fault_indicator && !wr_ctrl && !wr_cmd && !$past(wr_ctrl) && !$past(wr_cmd)
    |=> fault_indicator) else $error("fault memory lost");
  a_fault_quiet: assert property (
    fault_detect_n && !fault_indicator |=> !fault_indicator) else $error("false fault");
  a_ctrl_show: assert property (wr_ctrl && hready |-> ##2
    {termination_indicator, encoder_supply_indicator} == $past(hwdata[3:2], 2))
    else $error("indicator wrong");
  a_read_wait: assert property (
    hsel && htrans[1] && !hwrite && hready |=> !hreadyout ##1 hreadyout)
    else $error("read wait wrong");
  a_dir_fwd: assert property (fwd_step |-> ##[1:2] dir_positive)
    else $error("dir not positive");
  a_dir_rev: assert property (rev_step |-> ##[1:2] !dir_positive)
    else $error("dir not negative");
  c_over: cover property ($rose(overspeed_flag));
  c_index: cover property ($fell(index_seen));
  c_irq: cover property ($rose(irq));
endmodule : esm_chk
bind esm_top esm_chk #(.HOLD_CYC(HOLD_CYC), .STILL_CYC(STILL_CYC)) esm_chk_i (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .enc_a(enc_a), .enc_b(enc_b), .ref_pulse(ref_pulse), .fault_detect_n(fault_detect_n),
  .index_seen(index_seen), .fault_indicator(fault_indicator),
  .encoder_supply_indicator(encoder_supply_indicator),
  .termination_indicator(termination_indicator), .dir_positive(dir_positive),
  .overspeed_flag(overspeed_flag), .irq(irq));

// ==== bench/esm_top_tb.sv ====
`timescale 1ns/10ps
module esm_top_tb;
  localparam int unsigned HOLD = 50;
  logic hclk, hresetn, hsel, hwrite, ref_pulse, fault_n, amp_low, go, fwd;
  logic hready, hreadyout, hresp, enc_a, enc_b, idx, flt, sup, trm, dirp, ovs, irq;
  logic [31:0] haddr, hwdata, hrdata, v;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] gap;
  logic rdp = 1'b0;
  logic [31:0] eq[$];
  logic [31:0] mq[$];
  int miscompares = 0;
  int n_compared = 0;
  assign hready = hreadyout;
  esm_top #(.HOLD_CYC(HOLD), .STILL_CYC(40)) esm_top_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .enc_a(enc_a), .enc_b(enc_b),
    .ref_pulse(ref_pulse), .fault_detect_n(fault_n), .amp_low(amp_low),
    .index_seen(idx), .fault_indicator(flt), .encoder_supply_indicator(sup),
    .termination_indicator(trm), .dir_positive(dirp), .overspeed_flag(ovs), .irq(irq));
  esm_enc_model esm_enc_model_i (
    .hclk(hclk), .go(go), .fwd(fwd), .gap(gap), .enc_a(enc_a), .enc_b(enc_b));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask : check
  task automatic give_verdict();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : give_verdict
  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask : tick
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h00_0000, a};
    @(posedge hclk);
    while (!hreadyout) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (!hreadyout) @(posedge hclk);
    @(posedge hclk);
  endtask : xfer
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    eq.push_back(e);
    mq.push_back(m);
    xfer(1'b0, a, 32'h0);
  endtask : rd
  task automatic move(input logic f, input logic [7:0] g, input int n);
    fwd <= f;
    gap <= g;
    go <= 1'b1;
    tick(n);
    go <= 1'b0;
    tick(1);
  endtask : move
  // ----------------------------------------
  // read monitor and watchdog
  // ----------------------------------------
  always @(posedge hclk) begin
    if (rdp && hreadyout) begin
      check(hrdata & mq[0], eq[0] & mq[0]);
      check(32'(hresp), 32'h0);
      void'(eq.pop_front());
      void'(mq.pop_front());
    end
    if (hreadyout) begin
      rdp = hsel && htrans[1] && !hwrite;
    end
  end
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  initial begin
    tick(20000);
    miscompares++;
    give_verdict();
  end
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    {hresetn, hsel, hwrite, ref_pulse, amp_low, go, haddr, hwdata, htrans, gap} = '0;
    hsize = 3'h2;
    fault_n = 1'b1;
    fwd = 1'b1;
    void'($urandom(44650));
    tick(6);
    hresetn <= 1'b1;
    tick(1);
    check(32'(dirp), 32'h1);
    rd(8'h14, 32'h0000_0010, 32'hFFFF_FFFF);
    rd(8'h40, 32'h0, 32'hFFFF_FFFF);
    rd(8'h04, 32'h0, 32'hFFFF_FFFF);
    for (int i = 0; i < 4; i++) begin
      v = ($urandom & 32'hC) | 32'(i);
      xfer(1'b1, 8'h00, v);
      rd(8'h00, v, 32'hF);
      check(32'({trm, sup}), 32'(v[3:2]));
    end
    xfer(1'b1, 8'h00, 32'h1);
    tick(20);
    check(32'(flt), 32'h0);
    fault_n <= 1'b0;
    tick(3);
    check(32'({irq, flt}), 32'h1);
    rd(8'h08, 32'h6, 32'h6);
    fault_n <= 1'b1;
    tick(3);
    xfer(1'b1, 8'h00, 32'h1);
    rd(8'h08, 32'h4, 32'h6);
    xfer(1'b1, 8'h10, 32'h2);
    tick(1);
    check(32'(irq), 32'h1);
    xfer(1'b1, 8'h0C, 32'h2);
    check(32'({irq, flt}), 32'h1);
    xfer(1'b1, 8'h04, 32'h1);
    rd(8'h08, 32'h0, 32'h6);
    fault_n <= 1'b0;
    tick(2);
    fault_n <= 1'b1;
    tick(2);
    xfer(1'b1, 8'h00, 32'h2);
    rd(8'h08, 32'h0, 32'h6);
    ref_pulse <= 1'b1;
    tick(1);
    ref_pulse <= 1'b0;
    tick(3);
    check(32'(idx), 32'h1);
    tick(HOLD - 8);
    check(32'(idx), 32'h1);
    tick(12);
    check(32'(idx), 32'h0);
    rd(8'h0C, 32'h1, 32'h21);
    gap <= 8'h1D;
    go <= 1'b1;
    tick(40);
    ref_pulse <= 1'b1;
    tick(70);
    ref_pulse <= 1'b0;
    tick(70);
    go <= 1'b0;
    tick(1);
    check(32'(dirp), 32'h1);
    rd(8'h1C, 32'h6, 32'hFFFF);
    rd(8'h0C, 32'h20, 32'h24);
    move(1'b0, 8'h1D, 60);
    check(32'(dirp), 32'h0);
    move(1'b1, 8'h04, 20);
    check(32'(ovs), 32'h1);
    rd(8'h08, 32'h20, 32'h60);
    xfer(1'b1, 8'h00, 32'h3);
    move(1'b1, 8'h04, 20);
    rd(8'h08, 32'h60, 32'h60);
    xfer(1'b1, 8'h00, 32'h1);
    amp_low <= 1'b1;
    move(1'b1, 8'h04, 20);
    amp_low <= 1'b0;
    check(32'(ovs), 32'h0);
    rd(8'h08, 32'h80, 32'h80);
    xfer(1'b1, 8'h04, 32'h1);
    tick(60);
    amp_low <= 1'b1;
    tick(10);
    amp_low <= 1'b0;
    tick(1);
    rd(8'h08, 32'h0, 32'h90);
    give_verdict();
  end
endmodule : esm_top_tb
